// file: rtl/slc_lamp_map.vh
// Functional notes
// - Flash comm lamp while awaiting initialization
// - Init success: comm lamp steady on
// - Bad init data: comm lamp keeps flashing
// - Comm loss flashes, restore gives steady
// - Running mode: calibration lamp off
// - Calibration idle after init: cal lamp flashes
// - Calibration test: cal lamp steady on
// - During test comm lamp follows link
// - No communication: calibration lamp off
// - Module fault: comm lamp off
`ifndef SLC_LAMP_MAP_VH
`define SLC_LAMP_MAP_VH
`define SLC_CLK_HZ       40000000
`define SLC_FLASH_PER_NS 250000000
`define SLC_CLK_PER_NS   25
`define SLC_FLASH_CYC    (`SLC_FLASH_PER_NS / `SLC_CLK_PER_NS)
`define SLC_HALF_CYC     (`SLC_FLASH_CYC / 2)
`define SLC_ST_WAIT      2'h0
`define SLC_ST_RUN       2'h1
`define SLC_ST_LOST      2'h2
`define SLC_ST_FAULT     2'h3
`define SLC_LM_OFF       2'h0
`define SLC_LM_ON        2'h1
`define SLC_LM_FLASH     2'h2
`endif

// file: rtl/slc_flasher.v
`timescale 1ns/1ps
`include "slc_lamp_map.vh"

module slc_flasher #(
  parameter HALF_CYC = `SLC_HALF_CYC
) (
  input  wire clk_sys,   // System clock
  input  wire rst_n,     // Sync reset, active low
  output reg  flash      // Square wave, 250 ms period
);
  reg [22:0] cnt;

  // Half period each phase, even duty
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt   <= 23'h0;
      flash <= 1'b0;
    end else if (cnt == HALF_CYC - 1) begin
      cnt   <= 23'h0;
      flash <= ~flash;
    end else begin
      cnt <= cnt + 23'h1;
    end
  end
endmodule

// file: rtl/slc_lamp_ctrl.v
`timescale 1ns/1ps
`include "slc_lamp_map.vh"

module slc_lamp_ctrl #(
  parameter HALF_CYC = `SLC_HALF_CYC
) (
  input  wire clk_sys,    // System clock, 40 MHz
  input  wire rst_n,      // Sync reset, active low
  input  wire init_done,  // Initialization completed, valid data
  input  wire init_fail,  // Initialization data incorrect
  input  wire comm_ok,    // Communication with controller up
  input  wire fault,      // Internal module fault
  input  wire cal_mode,   // Calibration mode selected
  input  wire cal_test,   // Calibration test running
  output reg  lamp_comm,  // Green lamp drive, high lit
  output reg  lamp_cal    // Yellow lamp drive, high lit
);
  // Communication states
  localparam ST_WAIT  = `SLC_ST_WAIT;
  localparam ST_RUN   = `SLC_ST_RUN;
  localparam ST_LOST  = `SLC_ST_LOST;
  localparam ST_FAULT = `SLC_ST_FAULT;

  // Lamp indications
  localparam LM_OFF   = `SLC_LM_OFF;
  localparam LM_ON    = `SLC_LM_ON;
  localparam LM_FLASH = `SLC_LM_FLASH;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [2:0] s_init;
  reg [2:0] s_fail;
  reg [2:0] s_comm;
  reg [2:0] s_fault;
  reg [2:0] s_cmode;
  reg [2:0] s_test;
  reg       f_init;
  reg       f_fail;
  reg       f_comm;
  reg       f_fault;
  reg       f_cmode;
  reg       f_test;
  reg       next_f_init;
  reg       next_f_fail;
  reg       next_f_comm;
  reg       next_f_fault;
  reg       next_f_cmode;
  reg       next_f_test;
  reg       fault_seen;
  reg       next_fault_seen;
  reg       link_good;
  reg [1:0] comm_ind;
  reg [1:0] cal_ind;
  reg       next_comm;
  reg       next_cal;
  wire      flash;

  slc_flasher #(.HALF_CYC(HALF_CYC)) u_flash (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .flash   (flash)
  );

  // Take the stage 3 level once stages 2 and 3 agree
  function sync_accept;
    input [2:0] stages;
    input       held;
    begin
      if (stages[1] == stages[2])
        sync_accept = stages[2];
      else
        sync_accept = held;
    end
  endfunction

  // Drive level of a lamp for its indication
  // Flash follows the shared divider, so both lamps blink in phase
  function lamp_drive;
    input [1:0] mode;
    input       blink;
    begin
      case (mode)
        LM_OFF:   lamp_drive = 1'b0;
        LM_ON:    lamp_drive = 1'b1;
        LM_FLASH: lamp_drive = blink;
        default:  lamp_drive = 1'b0;
      endcase
    end
  endfunction

  // Each pin level passes three flops; a change is taken once
  // stages 2 and 3 agree, so a lamp answers five to six cycles
  // after a clean input edge. A single-cycle glitch never gets
  // as far as the state logic.

  // Initialization done
  // Sync and acceptance
  always @* begin
    next_f_init = sync_accept(s_init, f_init);
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      s_init <= 3'h0;
      f_init <= 1'b0;
    end else begin
      s_init <= {s_init[1:0], init_done};
      f_init <= next_f_init;
    end
  end

  // Initialization data bad
  // Sync and acceptance
  always @* begin
    next_f_fail = sync_accept(s_fail, f_fail);
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      s_fail <= 3'h0;
      f_fail <= 1'b0;
    end else begin
      s_fail <= {s_fail[1:0], init_fail};
      f_fail <= next_f_fail;
    end
  end

  // Communication up
  // Sync and acceptance
  always @* begin
    next_f_comm = sync_accept(s_comm, f_comm);
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      s_comm <= 3'h0;
      f_comm <= 1'b0;
    end else begin
      s_comm <= {s_comm[1:0], comm_ok};
      f_comm <= next_f_comm;
    end
  end

  // Module fault
  // Sync and acceptance
  always @* begin
    next_f_fault = sync_accept(s_fault, f_fault);
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      s_fault <= 3'h0;
      f_fault <= 1'b0;
    end else begin
      s_fault <= {s_fault[1:0], fault};
      f_fault <= next_f_fault;
    end
  end

  // Calibration mode select
  // Sync and acceptance
  always @* begin
    next_f_cmode = sync_accept(s_cmode, f_cmode);
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      s_cmode <= 3'h0;
      f_cmode <= 1'b0;
    end else begin
      s_cmode <= {s_cmode[1:0], cal_mode};
      f_cmode <= next_f_cmode;
    end
  end

  // Calibration test running
  // Sync and acceptance
  always @* begin
    next_f_test = sync_accept(s_test, f_test);
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      s_test <= 3'h0;
      f_test <= 1'b0;
    end else begin
      s_test <= {s_test[1:0], cal_test};
      f_test <= next_f_test;
    end
  end

  // Fault latch, cleared only by reset
  always @* begin
    next_fault_seen = fault_seen || f_fault;
  end

  always @(posedge clk_sys) begin
    if (!rst_n)
      fault_seen <= 1'b0;
    else
      fault_seen <= next_fault_seen;
  end

  // Initialization taken only with good data and a live link
  always @* begin
    link_good = f_init && !f_fail && f_comm;
  end

  // Communication state
  // A fault is terminal until reset, so a module that failed once
  // reads like an unpowered one and never lights steady again.
  // After start-up only the link level moves run and lost.
  always @* begin
    next_state = state;
    case (state)
      ST_WAIT: begin
        if (f_fault)
          next_state = ST_FAULT;
        else if (link_good)
          next_state = ST_RUN;
        else
          next_state = ST_WAIT;
      end
      ST_RUN: begin
        if (f_fault)
          next_state = ST_FAULT;
        else if (!f_comm)
          next_state = ST_LOST;
        else
          next_state = ST_RUN;
      end
      ST_LOST: begin
        if (f_fault)
          next_state = ST_FAULT;
        else if (f_comm)
          next_state = ST_RUN;
        else
          next_state = ST_LOST;
      end
      ST_FAULT: begin
        next_state = ST_FAULT;
      end
      default: next_state = ST_WAIT;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n)
      state <= ST_WAIT;
    else
      state <= next_state;
  end

  // Green lamp indication
  // Latched fault overrides any state
  always @* begin
    comm_ind = LM_OFF;
    case (state)
      ST_WAIT:  comm_ind = LM_FLASH;
      ST_RUN:   comm_ind = LM_ON;
      ST_LOST:  comm_ind = LM_FLASH;
      ST_FAULT: comm_ind = LM_OFF;
      default:  comm_ind = LM_OFF;
    endcase
    if (fault_seen)
      comm_ind = LM_OFF;
  end

  // Yellow lamp indication
  // Lit only in calibration mode with the link up
  always @* begin
    cal_ind = LM_OFF;
    if (f_cmode && state == ST_RUN && !fault_seen) begin
      if (f_test)
        cal_ind = LM_ON;
      else
        cal_ind = LM_FLASH;
    end
  end

  // Both lamps share one flash phase
  always @* begin
    next_comm = lamp_drive(comm_ind, flash);
  end

  always @* begin
    next_cal = lamp_drive(cal_ind, flash);
  end

  // Lamp drives straight from flops
  always @(posedge clk_sys) begin
    if (!rst_n)
      lamp_comm <= 1'b0;
    else
      lamp_comm <= next_comm;
  end

  always @(posedge clk_sys) begin
    if (!rst_n)
      lamp_cal <= 1'b0;
    else
      lamp_cal <= next_cal;
  end
endmodule

// file: bench/slc_host.sv
`timescale 1ns/1ps
// Controller side: link state and init data outcome
module slc_host(input wire clk_sys, link_up, bad_data,
  output reg init_done = 0, init_fail = 0, comm_ok = 0);
  always @(posedge clk_sys) begin
    comm_ok <= link_up;
    init_fail <= link_up & bad_data;
    init_done <= link_up & ~bad_data;
  end
endmodule

// file: bench/slc_lamp_ctrl_asserts.sv
`timescale 1ns/1ps
module slc_lamp_ctrl_asserts(input wire clk_sys, rst_n, init_done,
  init_fail, comm_ok, fault, cal_mode, cal_test, lamp_comm, lamp_cal);
  reg flt = 1'b0;
  wire good = init_done && !init_fail && comm_ok && !flt;
  // Fault is sticky until reset
  always @(posedge clk_sys) flt <= rst_n && (flt || fault);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_reset_dark: assert property (
    $rose(rst_n) |-> !lamp_comm && !lamp_cal) else $error("lamp lit");
  chk_cal_run_off: assert property (
    !cal_mode[*8] |-> !lamp_cal) else $error("cal lit");
  chk_cal_nocomm: assert property (
    !comm_ok[*8] |-> !lamp_cal) else $error("cal lit");
  chk_fault_dark: assert property (
    fault[*8] |-> !lamp_comm) else $error("comm lit");
  chk_comm_steady: assert property (
    good[*8] |-> lamp_comm) else $error("comm dark");
  chk_comm_flash: assert property (
    (!comm_ok && !flt)[*8] ##0 $fell(lamp_comm) |-> !lamp_comm[*4] ##1
    lamp_comm) else $error("comm flash");
  chk_cal_test_on: assert property (
    (good && cal_mode && cal_test)[*8] |-> lamp_cal) else $error("cal dark");
  chk_cal_flash: assert property (
    (good && cal_mode && !cal_test)[*8] ##0 $fell(lamp_cal) |->
    !lamp_cal[*4] ##1 lamp_cal) else $error("cal flash");
  cover property (good && cal_mode && cal_test);
  cover property ($fell(lamp_comm));
  cover property (flt);
endmodule
bind slc_lamp_ctrl slc_lamp_ctrl_asserts i_chk(.clk_sys, .rst_n,
  .init_done, .init_fail, .comm_ok, .fault, .cal_mode, .cal_test,
  .lamp_comm, .lamp_cal);

// file: bench/slc_lamp_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(a,e) begin num_checks++; if ((a)!==(e)) begin fail_count++; \
  $display("[FAIL] %0t %h %h", $time, a, e); end end
module slc_lamp_ctrl_test;
  reg clk_sys=0, rst_n=0, fault=0, link_up=0, bad_data=0, cal_mode=0;
  reg cal_test=0;
  wire init_done, init_fail, comm_ok, lamp_comm, lamp_cal;
  logic [3:0] nc, ny;
  int fail_count=0, num_checks=0;
  slc_host i_host(.clk_sys, .link_up, .bad_data, .init_done, .init_fail,
    .comm_ok);
  slc_lamp_ctrl #(.HALF_CYC(4)) i_dut(.clk_sys, .rst_n, .init_done,
    .init_fail, .comm_ok, .fault, .cal_mode, .cal_test, .lamp_comm,
    .lamp_cal);
  initial forever #12.5 clk_sys = ~clk_sys;
  initial begin repeat (1000) @(posedge clk_sys); fail_count++; test_done; end
  task test_done;
    if (fail_count==0 && num_checks>0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Apply inputs, settle, count lit cycles of each lamp over one period
  task step(input [4:0] s, input [7:0] e);
    @(posedge clk_sys) {fault,link_up,bad_data,cal_mode,cal_test} <= s;
    nc = 0;
    ny = 0;
    repeat (12) @(negedge clk_sys);
    repeat (8) begin @(negedge clk_sys); nc += lamp_comm; ny += lamp_cal; end
    `CHK({nc, ny}, e)
  endtask
  task t_boot;
    step(5'h00, 8'h40);
    step(5'h0c, 8'h40);
  endtask
  task t_run;
    step(5'h08, 8'h80);
    step(5'h00, 8'h40);
    step(5'h08, 8'h80);
  endtask
  task t_cal;
    step(5'h0a, 8'h84);
    step(5'h0b, 8'h88);
    step(5'h03, 8'h40);
    step(5'h0b, 8'h88);
    step(5'h0a, 8'h84);
  endtask
  task t_fault;
    step(5'h1a, 8'h00);
    step(5'h0a, 8'h00);
  endtask
  // Mid-run reset clears the latched fault
  task t_reset;
    @(posedge clk_sys) begin
      rst_n <= 0;
      {fault,link_up,bad_data,cal_mode,cal_test} <= 5'h00;
    end
    repeat (3) @(posedge clk_sys);
    `CHK({lamp_comm, lamp_cal}, 2'h0)
    rst_n <= 1;
    step(5'h00, 8'h40);
    step(5'h08, 8'h80);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1;
    t_boot;
    t_run;
    t_cal;
    t_fault;
    t_reset;
    test_done;
  end
endmodule
